// [rtl/adcpsf_top.sv]
// Summary of operation
// - Each conversion follows at least one conversion clock period of sampling.
// - Sampling ends by software clearing the sample bit, or automatically.
// - Power-on bit set means fully working; clear disables the module.
// - In sleep without the RC clock selected, all converter clocks stop and stay low.
// - Sleep without the RC clock selected aborts a running conversion; it never resumes afterwards.
// - Entering or leaving sleep leaves register contents unchanged.
// - With the RC clock selected it runs in sleep, starting one instruction later.
// - A finished conversion sets the done flag and stores the result.
// - Completion in sleep wakes the device if enabled, else turns module off.
// - Stop-in-idle bit zero keeps running in idle; one halts it.
// - Device reset restores registers, powers off and aborts any sequence.
// - Result buffer is untouched by device reset; undefined after power-on.
// - Results and buffer entries are ten bits wide.
// - Format field picks four formats; integer zero-fills, signed integer sign-extends.
// - Reads give sixteen bits; fractional formats left-justify with six low zeros.
// - Software writes into the buffer are taken right-justified.
// - Port reads give zero on analog pins; output pins convert their driven level.
// - A digital input pin never supplies an analog value.
// - Sequencing ignores channel selects and pin directions.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module adcpsf_top (
  input wire logic clk, // System clock
  input wire logic rst, // Device reset, async high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write strobe
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic sleep_mode, // CPU sleep
  input wire logic idle_mode, // CPU idle
  input wire logic irq_enabled, // Converter interrupt enabled
  input wire logic [15:0] pin_in, // Raw pin levels
  input wire logic [15:0] pin_out, // Port output latch
  input wire logic [9:0] analog_code, // Front-end code of selected pin
  output logic afe_power_en, // Analog power
  output logic afe_sample_en, // Sample switch closed
  output logic afe_clk_en, // Conversion clock tick
  output logic [3:0] afe_channel, // Selected channel
  output logic conv_done, // Completion pulse
  output logic wake_req // Wake from sleep pulse
);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_DELAY, ST_CONV} adcpsf_state_t;

  adcpsf_state_t state_reg;
  logic pend_reg, pend_wr_reg;
  logic [7:0] pend_addr_reg;
  logic power_on_reg, sample_control_bit_reg, asam_reg, rc_sel_reg, sidl_reg;
  logic [1:0] form_reg;
  logic [5:0] adcs_reg;
  logic [4:0] samc_reg;
  logic [15:0] pincfg_reg, pindir_reg;
  logic [3:0] chsel_a_reg, chsel_b_reg;
  logic done_reg, sleep_off_reg;
  logic [3:0] wptr_reg;
  logic [9:0] result_buffer [adcpsf_pkg::BUF_DEPTH];
  logic [9:0] hold_reg;
  logic [5:0] tad_cnt_reg;
  logic [4:0] sample_control_bit_tads_reg;
  logic [3:0] conv_cnt_reg;
  logic [2:0] dly_cnt_reg;
  logic [15:0] sync1_reg, sync2_reg, sync3_reg, pin_state_reg;
  logic [31:0] rd_next;
  logic wr_en, running, halted, abort, tad_tick, start_conv, conv_end;
  logic [4:0] samc_min;
  logic [9:0] src_value;

  function automatic logic [15:0] adcpsf_format(input logic [1:0] form, input logic [9:0] d);
    logic [15:0] v;
    v = 16'h0000;
    unique case (form)
      adcpsf_pkg::FMT_INT: v = {6'h00, d};
      adcpsf_pkg::FMT_SINT: v = {{6{d[9]}}, d};
      adcpsf_pkg::FMT_FRAC, adcpsf_pkg::FMT_SFRAC: v = {d, 6'h00};
    endcase
    return v;
  endfunction : adcpsf_format

  function automatic logic in_buf(input logic [7:0] a);
    return a >= adcpsf_pkg::OFF_BUF && a <= adcpsf_pkg::OFF_BUF_END;
  endfunction : in_buf

  // Bus slave: one wait state, write in data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      pend_addr_reg <= 8'h00;
      hreadyout <= 1'b1;
    end else if (pend_reg) begin
      pend_reg <= 1'b0;
      hreadyout <= 1'b1;
    end else if (hsel && hready && htrans[1]) begin
      pend_reg <= 1'b1;
      pend_wr_reg <= hwrite;
      pend_addr_reg <= {haddr[7:2], 2'h0};
      hreadyout <= 1'b0;
    end
  end

  assign wr_en = pend_reg && pend_wr_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    if (in_buf(pend_addr_reg)) begin
      rd_next[15:0] = adcpsf_format(form_reg, result_buffer[pend_addr_reg[5:2]]);
    end else begin
      unique case (pend_addr_reg)
        adcpsf_pkg::OFF_CTRL: begin
          rd_next[adcpsf_pkg::BIT_PWR] = power_on_reg;
          rd_next[adcpsf_pkg::BIT_SAMPLE_CONTROL_BIT] = sample_control_bit_reg;
          rd_next[adcpsf_pkg::BIT_ASAM] = asam_reg;
          rd_next[adcpsf_pkg::BIT_RC] = rc_sel_reg;
          rd_next[adcpsf_pkg::BIT_SIDL] = sidl_reg;
          rd_next[adcpsf_pkg::FORM_LSB +: 2] = form_reg;
        end
        adcpsf_pkg::OFF_TIMING: begin
          rd_next[adcpsf_pkg::ADCS_LSB +: adcpsf_pkg::ADCS_W] = adcs_reg;
          rd_next[adcpsf_pkg::SAMC_LSB +: adcpsf_pkg::SAMC_W] = samc_reg;
        end
        adcpsf_pkg::OFF_STATUS: begin
          rd_next[adcpsf_pkg::BIT_DONE] = done_reg;
          rd_next[adcpsf_pkg::BIT_BUSY] = (state_reg == ST_CONV) || (state_reg == ST_DELAY);
          rd_next[adcpsf_pkg::BIT_SLPOFF] = sleep_off_reg;
          rd_next[adcpsf_pkg::PTR_LSB +: adcpsf_pkg::PTR_W] = wptr_reg;
        end
        adcpsf_pkg::OFF_PINCFG: rd_next[15:0] = pincfg_reg;
        adcpsf_pkg::OFF_PINDIR: rd_next[15:0] = pindir_reg;
        adcpsf_pkg::OFF_CHSEL: rd_next[7:0] = {chsel_b_reg, chsel_a_reg};
        adcpsf_pkg::OFF_PORT: rd_next[15:0] = pin_state_reg & pincfg_reg;
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else if (pend_reg && !pend_wr_reg) begin
      hrdata <= rd_next;
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      sync3_reg <= 16'h0000;
      pin_state_reg <= 16'h0000;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < adcpsf_pkg::NPIN; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_state_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Configuration registers; sleep never touches them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_on_reg <= 1'b0;
      asam_reg <= 1'b0;
      rc_sel_reg <= 1'b0;
      sidl_reg <= 1'b0;
      form_reg <= adcpsf_pkg::FMT_INT;
      adcs_reg <= 6'h00;
      samc_reg <= 5'h00;
      pincfg_reg <= adcpsf_pkg::PINCFG_RST;
      pindir_reg <= adcpsf_pkg::PINDIR_RST;
      chsel_a_reg <= 4'h0;
      chsel_b_reg <= 4'h0;
    end else if (wr_en) begin
      unique case (pend_addr_reg)
        adcpsf_pkg::OFF_CTRL: begin
          power_on_reg <= hwdata[adcpsf_pkg::BIT_PWR];
          asam_reg <= hwdata[adcpsf_pkg::BIT_ASAM];
          rc_sel_reg <= hwdata[adcpsf_pkg::BIT_RC];
          sidl_reg <= hwdata[adcpsf_pkg::BIT_SIDL];
          form_reg <= hwdata[adcpsf_pkg::FORM_LSB +: 2];
        end
        adcpsf_pkg::OFF_TIMING: begin
          adcs_reg <= hwdata[adcpsf_pkg::ADCS_LSB +: adcpsf_pkg::ADCS_W];
          samc_reg <= hwdata[adcpsf_pkg::SAMC_LSB +: adcpsf_pkg::SAMC_W];
        end
        adcpsf_pkg::OFF_PINCFG: pincfg_reg <= hwdata[15:0];
        adcpsf_pkg::OFF_PINDIR: pindir_reg <= hwdata[15:0];
        adcpsf_pkg::OFF_CHSEL: begin
          chsel_a_reg <= hwdata[3:0];
          chsel_b_reg <= hwdata[adcpsf_pkg::CHB_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // Run conditions
  assign halted = idle_mode && sidl_reg;
  assign abort = !power_on_reg || sleep_off_reg || (sleep_mode && !rc_sel_reg);
  assign running = !abort && !halted;
  assign samc_min = (samc_reg < 5'(adcpsf_pkg::SAMPLE_CONTROL_BIT_MIN_TAD)) ?
                    5'(adcpsf_pkg::SAMPLE_CONTROL_BIT_MIN_TAD) : samc_reg;

  // Conversion clock divider; stopped whenever not running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tad_cnt_reg <= 6'h00;
    end else if (!running || tad_cnt_reg == 6'h00) begin
      tad_cnt_reg <= rc_sel_reg ? 6'(adcpsf_pkg::RC_TAD_CYC - 1) : adcs_reg;
    end else begin
      tad_cnt_reg <= tad_cnt_reg - 6'h01;
    end
  end
  assign tad_tick = running && tad_cnt_reg == 6'h00;

  // Signal presented for sampling; digital inputs never supply a value
  always_comb begin
    src_value = 10'h000;
    if (!pincfg_reg[chsel_a_reg]) begin
      if (pindir_reg[chsel_a_reg]) begin
        src_value = analog_code;
      end else begin
        src_value = pin_out[chsel_a_reg] ? adcpsf_pkg::FULL_SCALE : 10'h000;
      end
    end
  end

  // Sequencer: state flow ignores channel and direction settings
  assign start_conv = state_reg == ST_SAMPLE && running &&
                      sample_control_bit_tads_reg >= 5'(adcpsf_pkg::SAMPLE_CONTROL_BIT_MIN_TAD) &&
                      (asam_reg ? sample_control_bit_tads_reg >= samc_min : !sample_control_bit_reg);
  assign conv_end = state_reg == ST_CONV && tad_tick &&
                    conv_cnt_reg == 4'(adcpsf_pkg::CONV_TADS - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      sample_control_bit_tads_reg <= 5'h00;
      conv_cnt_reg <= 4'h0;
      dly_cnt_reg <= 3'h0;
      hold_reg <= 10'h000;
    end else if (abort) begin
      state_reg <= ST_IDLE;
    end else if (!halted) begin
      unique case (state_reg)
        ST_IDLE: begin
          sample_control_bit_tads_reg <= 5'h00;
          if (sample_control_bit_reg || asam_reg) begin
            state_reg <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tad_tick && sample_control_bit_tads_reg != 5'h1F) begin
            sample_control_bit_tads_reg <= sample_control_bit_tads_reg + 5'h01;
          end
          if (start_conv) begin
            hold_reg <= src_value;
            conv_cnt_reg <= 4'h0;
            dly_cnt_reg <= 3'h0;
            state_reg <= rc_sel_reg ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          if (dly_cnt_reg == 3'(adcpsf_pkg::TCY_CYC - 1)) begin
            state_reg <= ST_CONV;
          end else begin
            dly_cnt_reg <= dly_cnt_reg + 3'h1;
          end
        end
        ST_CONV: begin
          if (tad_tick) begin
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
          end
          if (conv_end) begin
            sample_control_bit_tads_reg <= 5'h00;
            state_reg <= asam_reg ? ST_SAMPLE : ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sample bit: hardware set or clear wins over software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_control_bit_reg <= 1'b0;
    end else if (asam_reg && start_conv && !halted) begin
      sample_control_bit_reg <= 1'b0;
    end else if (asam_reg && conv_end && !halted) begin
      sample_control_bit_reg <= 1'b1;
    end else if (wr_en && pend_addr_reg == adcpsf_pkg::OFF_CTRL) begin
      sample_control_bit_reg <= hwdata[adcpsf_pkg::BIT_SAMPLE_CONTROL_BIT];
    end
  end

  // Done flag, sleep power-off and wake; a set beats a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
      sleep_off_reg <= 1'b0;
      wake_req <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= conv_end && !halted;
      wake_req <= conv_end && !halted && sleep_mode && irq_enabled;
      if (conv_end && !halted) begin
        done_reg <= 1'b1;
      end else if (wr_en && pend_addr_reg == adcpsf_pkg::OFF_STATUS &&
                   !hwdata[adcpsf_pkg::BIT_DONE]) begin
        done_reg <= 1'b0;
      end
      if (conv_end && !halted && sleep_mode && !irq_enabled) begin
        sleep_off_reg <= 1'b1;
      end else if (wr_en && pend_addr_reg == adcpsf_pkg::OFF_CTRL) begin
        sleep_off_reg <= 1'b0;
      end
    end
  end

  // Result buffer: no reset so device reset leaves it alone
  always_ff @(posedge clk) begin
    if (conv_end && !halted) begin
      result_buffer[wptr_reg] <= hold_reg;
    end else if (wr_en && in_buf(pend_addr_reg)) begin
      result_buffer[pend_addr_reg[5:2]] <= hwdata[9:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= 4'h0;
    end else if (conv_end && !halted) begin
      wptr_reg <= wptr_reg + 4'h1;
    end
  end

  // Front-end controls; clocks held low outside running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      afe_power_en <= 1'b0;
      afe_sample_en <= 1'b0;
      afe_clk_en <= 1'b0;
      afe_channel <= 4'h0;
    end else begin
      afe_power_en <= power_on_reg && !sleep_off_reg;
      afe_sample_en <= running && state_reg == ST_SAMPLE;
      afe_clk_en <= tad_tick;
      afe_channel <= chsel_a_reg;
    end
  end

  property p_int_fmt;
    @(posedge clk) disable iff (rst)
    (pend_reg && !pend_wr_reg && in_buf(pend_addr_reg) && form_reg == adcpsf_pkg::FMT_INT)
      |=> hrdata[15:10] == 6'h00 && hrdata[9:0] == $past(result_buffer[pend_addr_reg[5:2]]);
  endproperty
  a_int_fmt: assert property (p_int_fmt) else $error("integer format wrong");

  property p_frac_fmt;
    @(posedge clk) disable iff (rst)
    (pend_reg && !pend_wr_reg && in_buf(pend_addr_reg) && form_reg[1])
      |=> hrdata[5:0] == 6'h00 && hrdata[31:16] == 16'h0000;
  endproperty
  a_frac_fmt: assert property (p_frac_fmt) else $error("fraction format wrong");

  property p_min_sample;
    @(posedge clk) disable iff (rst)
    (state_reg == ST_SAMPLE ##1 state_reg inside {ST_CONV, ST_DELAY})
      |-> $past(sample_control_bit_tads_reg) >= 5'h01;
  endproperty
  a_min_sample: assert property (p_min_sample) else $error("sample too short");

  property p_sleep_clk;
    @(posedge clk) disable iff (rst)
    (sleep_mode && !rc_sel_reg) [*2] |-> !afe_clk_en && !afe_sample_en;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("clock ran in sleep");

  property p_sleep_abort;
    @(posedge clk) disable iff (rst)
    (sleep_mode && !rc_sel_reg && state_reg == ST_CONV) |=> state_reg == ST_IDLE;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("conversion not aborted");

  sequence s_delay_enter;
    state_reg == ST_SAMPLE ##1 state_reg == ST_DELAY;
  endsequence
  property p_rc_delay;
    @(posedge clk) disable iff (rst)
    (s_delay_enter ##0 (!halted && !abort) [*7]) |->
      state_reg == ST_DELAY ##1 state_reg == ST_CONV;
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start delay wrong");

  property p_done;
    @(posedge clk) disable iff (rst)
    (conv_end && !halted) |=> done_reg && conv_done && wptr_reg == $past(wptr_reg) + 4'h1;
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_wake;
    @(posedge clk) disable iff (rst)
    (conv_end && !halted && sleep_mode) |=> (irq_enabled ? wake_req : sleep_off_reg)
      ##1 (!$past(irq_enabled, 2) -> !afe_power_en);
  endproperty
  a_wake: assert property (p_wake) else $error("sleep completion wrong");

  property p_idle_halt;
    @(posedge clk) disable iff (rst)
    (halted && !abort && state_reg == ST_CONV) |=> $stable(conv_cnt_reg) && !afe_clk_en;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("ran while idle halted");

  property p_port_read;
    @(posedge clk) disable iff (rst)
    (pend_reg && !pend_wr_reg && pend_addr_reg == adcpsf_pkg::OFF_PORT)
      |=> (hrdata[15:0] & ~pincfg_reg) == 16'h0000;
  endproperty
  a_port_read: assert property (p_port_read) else $error("analog pin read nonzero");

  property p_power_off;
    @(posedge clk) disable iff (rst)
    !power_on_reg |=> state_reg == ST_IDLE && !afe_power_en;
  endproperty
  a_power_off: assert property (p_power_off) else $error("ran while off");
endmodule : adcpsf_top

// [rtl/adcpsf_pkg.sv]
package adcpsf_pkg;
  localparam int DATA_W = 10;
  localparam int BUS_W = 16;
  localparam int NPIN = 16;
  localparam int BUF_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int OFF_W = 8;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMING = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PINCFG = 8'h0C;
  localparam logic [7:0] OFF_PINDIR = 8'h10;
  localparam logic [7:0] OFF_CHSEL = 8'h14;
  localparam logic [7:0] OFF_PORT = 8'h18;
  localparam logic [7:0] OFF_BUF = 8'h40;
  localparam logic [7:0] OFF_BUF_END = 8'h7C;

  localparam int BIT_PWR = 0;
  localparam int BIT_SAMPLE_CONTROL_BIT = 1;
  localparam int BIT_ASAM = 2;
  localparam int BIT_RC = 3;
  localparam int BIT_SIDL = 4;
  localparam int FORM_LSB = 8;
  localparam int BIT_DONE = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_SLPOFF = 2;
  localparam int PTR_LSB = 4;
  localparam int ADCS_LSB = 0;
  localparam int ADCS_W = 6;
  localparam int SAMC_LSB = 8;
  localparam int SAMC_W = 5;
  localparam int CHB_LSB = 4;

  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  localparam logic [15:0] PINCFG_RST = 16'h0000;
  localparam logic [15:0] PINDIR_RST = 16'hFFFF;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;

  localparam int CLK_NS = 5;
  localparam int TCY_NS = 33;
  localparam int TCY_CYC = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_TAD_NS = 250;
  localparam int RC_TAD_CYC = (RC_TAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CONTROL_BIT_MIN_TAD = 1;
  localparam int CONV_TADS = 12;
endpackage : adcpsf_pkg

// [bench/adcpsf_afe_model.sv]
`timescale 1ns/10ps
module adcpsf_afe_model (
  input wire logic clk, // System clock
  input wire logic power_en, // Analog power
  input wire logic sample_en, // Sample switch
  input wire logic [3:0] channel, // Selected channel
  output logic [9:0] code // Held sample code
);
  initial code = 10'h155;
  always @(posedge clk) begin
    if (!power_en) begin
      code <= ~code; // Unpowered front end gives no stable code
    end else if (sample_en) begin
      code <= {channel, 6'h2D};
    end
  end
endmodule : adcpsf_afe_model

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] ctl_pwr = 32'h1 << adcpsf_pkg::BIT_PWR;
  localparam logic [31:0] ctl_sample = 32'h1 << adcpsf_pkg::BIT_SAMPLE_CONTROL_BIT;
  localparam logic [31:0] ctl_auto = 32'h1 << adcpsf_pkg::BIT_ASAM;
  localparam logic [31:0] ctl_rc = 32'h1 << adcpsf_pkg::BIT_RC;
  localparam logic [31:0] ctl_sidl = 32'h1 << adcpsf_pkg::BIT_SIDL;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, afe_power_en, afe_sample_en, afe_clk_en, conv_done, wake_req;
  logic sleep_mode = 1'b0, irq_enabled = 1'b0, idle_mode = 1'b0;
  logic [15:0] pin_in = 16'h0, pin_out = 16'h0;
  logic [9:0] analog_code;
  logic [3:0] afe_channel;
  int miscompares = 0, tests_run = 0, cyc = 0;

  adcpsf_top u_adcpsf_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .irq_enabled(irq_enabled), .pin_in(pin_in), .pin_out(pin_out),
    .analog_code(analog_code), .afe_power_en(afe_power_en), .afe_sample_en(afe_sample_en),
    .afe_clk_en(afe_clk_en), .afe_channel(afe_channel), .conv_done(conv_done),
    .wake_req(wake_req));
  adcpsf_afe_model u_adcpsf_afe_model (.clk(clk), .power_en(afe_power_en),
    .sample_en(afe_sample_en), .channel(afe_channel), .code(analog_code));

  always #2.5 clk = ~clk;

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(nm, r, e);
    check("hresp", hresp, 1'b0);
  endtask : rdc

  task wpulse(input bit wk, output bit got);
    got = 1'b0;
    for (int n = 0; n < 3000 && !got; n++) begin
      @(posedge clk);
      got = wk ? wake_req === 1'b1 : conv_done === 1'b1;
    end
  endtask : wpulse

  task quiet(input bit ck, output bit got);
    got = 1'b0;
    repeat (2) @(posedge clk);
    repeat (100) begin
      @(posedge clk);
      if (conv_done === 1'b1 || (ck && afe_clk_en === 1'b1)) got = 1'b1;
    end
  endtask : quiet

  function logic [15:0] fmt(input logic [1:0] f, input logic [9:0] d);
    case (f)
      adcpsf_pkg::FMT_INT: fmt = {6'h00, d};
      adcpsf_pkg::FMT_SINT: fmt = {{6{d[9]}}, d};
      default: fmt = {d, 6'h00};
    endcase
  endfunction : fmt

  function logic [31:0] exp_code(input logic [3:0] ch, input logic [15:0] cfg, dir, po);
    if (cfg[ch]) exp_code = 32'h0;
    else if (dir[ch]) exp_code = {22'h0, ch, 6'h2D};
    else exp_code = po[ch] ? 32'h3FF : 32'h0;
  endfunction : exp_code

  initial begin
    logic [31:0] r, d, e;
    logic [7:0] ba;
    logic [15:0] cfg, dir;
    logic [3:0] ch;
    bit got;
    void'($urandom(63));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("ctrl", adcpsf_pkg::OFF_CTRL, 32'h0);
    rdc("pincfg", adcpsf_pkg::OFF_PINCFG, {16'h0, adcpsf_pkg::PINCFG_RST});
    rdc("pindir", adcpsf_pkg::OFF_PINDIR, {16'h0, adcpsf_pkg::PINDIR_RST});
    rdc("status", adcpsf_pkg::OFF_STATUS, 32'h0);
    wr(8'h30, 32'hFFFF);
    rdc("unmapped", 8'h30, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[9] = i[2];
      ba = adcpsf_pkg::OFF_BUF + 8'(i * 4);
      wr(ba, d);
      wr(adcpsf_pkg::OFF_CTRL, {22'h0, i[1:0], 8'h00});
      rdc("format", ba, {16'h0, fmt(i[1:0], d[9:0])});
    end
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr);
    repeat (8) @(posedge clk);
    wr(adcpsf_pkg::OFF_TIMING, 32'h1);
    pin_in <= 16'($urandom);
    cfg = 16'($urandom);
    wr(adcpsf_pkg::OFF_PINCFG, cfg);
    repeat (6) @(posedge clk);
    rdc("port", adcpsf_pkg::OFF_PORT, {16'h0, pin_in & cfg});
    pin_out <= 16'($urandom);
    for (int i = 0; i < 8; i++) begin
      ch = 4'($urandom);
      cfg = 16'($urandom);
      dir = 16'($urandom);
      if (i < 3) cfg[ch] = i == 0;
      if (i < 3) dir[ch] = i != 2;
      if (cfg[ch]) dir[ch] = 1'b1;
      wr(adcpsf_pkg::OFF_PINCFG, cfg);
      wr(adcpsf_pkg::OFF_PINDIR, dir);
      wr(adcpsf_pkg::OFF_CHSEL, {28'h0, ch});
      bus(1'b0, adcpsf_pkg::OFF_STATUS, 32'h0, r);
      ba = adcpsf_pkg::OFF_BUF + {2'h0, r[7:4], 2'h0};
      wr(adcpsf_pkg::OFF_CTRL, ctl_pwr | ctl_sample);
      wr(adcpsf_pkg::OFF_CTRL, ctl_pwr);
      wpulse(1'b0, got);
      check("conv_done", got, 1'b1);
      e = exp_code(ch, cfg, dir, pin_out);
      rdc("result", ba, e);
      bus(1'b0, adcpsf_pkg::OFF_STATUS, 32'h0, r);
      check("done", r[adcpsf_pkg::BIT_DONE], 1'b1);
      wr(adcpsf_pkg::OFF_STATUS, 32'h0);
    end
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr | ctl_sample);
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr);
    repeat (6) @(posedge clk);
    sleep_mode <= 1'b1;
    quiet(1'b1, got);
    check("sleep_quiet", got, 1'b0);
    sleep_mode <= 1'b0;
    quiet(1'b0, got);
    check("no_resume", got, 1'b0);
    rdc("ctrl_kept", adcpsf_pkg::OFF_CTRL, ctl_pwr);
    idle_mode <= 1'b1;
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr | ctl_sample);
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr);
    wpulse(1'b0, got);
    check("idle_run", got, 1'b1);
    idle_mode <= 1'b0;
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr | ctl_sidl | ctl_sample);
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr | ctl_sidl);
    repeat (6) @(posedge clk);
    idle_mode <= 1'b1;
    quiet(1'b1, got);
    check("idle_halt", got, 1'b0);
    idle_mode <= 1'b0;
    wpulse(1'b0, got);
    check("idle_resume", got, 1'b1);
    irq_enabled <= 1'b1;
    wr(adcpsf_pkg::OFF_TIMING, 32'h0101);
    wr(adcpsf_pkg::OFF_CTRL, ctl_pwr | ctl_auto | ctl_rc);
    sleep_mode <= 1'b1;
    wpulse(1'b1, got);
    check("wake", got, 1'b1);
    irq_enabled <= 1'b0;
    wpulse(1'b0, got);
    check("sleep_done", got, 1'b1);
    repeat (4) @(posedge clk);
    check("sleep_off", afe_power_en, 1'b0);
    sleep_mode <= 1'b0;
    bus(1'b0, adcpsf_pkg::OFF_STATUS, 32'h0, r);
    check("slpoff_bit", r[adcpsf_pkg::BIT_SLPOFF], 1'b1);
    bus(1'b0, adcpsf_pkg::OFF_CTRL, 32'h0, r);
    check("pwr_kept", r[adcpsf_pkg::BIT_PWR], 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset_pwr", {afe_power_en, afe_sample_en}, 2'h0);
    rdc("reset_ctrl", adcpsf_pkg::OFF_CTRL, 32'h0);
    rdc("buf_kept", ba, e);
    finish_test();
  end
endmodule : tb_top
